// >>> pmc_pkg.sv
`default_nettype none
package pmc_pkg;
    localparam int NUM_EVT = 8;
    localparam int EVT_W = 16;
    localparam int CYC_W = 32;
    localparam int SEL_W = 8;
    // Event codes on the selector
    localparam logic [7:0] EV_SOFTWARE_INCREMENT_EVENT = 8'h00;
    localparam logic [7:0] EV_CHAIN = 8'h1e;
    // Device register offsets (word index on the link)
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_CNT_EN_SET = 6'h01;
    localparam logic [5:0] OFS_CNT_EN_CLR = 6'h02;
    localparam logic [5:0] OFS_SW_INC = 6'h03;
    localparam logic [5:0] OFS_OVF_STAT = 6'h04;
    localparam logic [5:0] OFS_OVF_CLR = 6'h05;
    localparam logic [5:0] OFS_CYC_VAL = 6'h06;
    localparam logic [5:0] OFS_EVT_CNT0 = 6'h10;
    localparam logic [5:0] OFS_EVT_SEL0 = 6'h20;
    // Control register bits
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_EVRST_BIT = 1;
    localparam int CTRL_CYCRST_BIT = 2;
    // Bit 31 of enable and overflow words belongs to the cycle counter
    localparam int CYC_BIT = 31;
    // Host AHB register offsets
    localparam logic [7:0] H_CMD = 8'h00;
    localparam logic [7:0] H_WDATA = 8'h04;
    localparam logic [7:0] H_RDATA = 8'h08;
    localparam logic [7:0] H_STAT = 8'h0c;
    localparam logic [7:0] H_MASK = 8'h10;
    localparam logic [7:0] H_TRACE = 8'h14;
    // Command word: bit 8 = write, bits 5:0 = device offset
    localparam int CMD_WR_BIT = 8;
endpackage
`default_nettype wire

// >>> pmc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pmc_if;
    logic req;
    logic wr;
    logic [5:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic trace_global_enable;
    modport dev (input req, input wr, input addr, input wdata, input trace_global_enable, output rdata);
    modport host (output req, output wr, output addr, output wdata, output trace_global_enable, input rdata);
endinterface
`default_nettype wire

// >>> pmc_evt_counter.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_evt_counter #(
    parameter int W = 16
) (
    input wire logic core_clk, // Clock
    input wire logic sys_rst, // Async reset
    input wire logic clr, // Zero strobe
    input wire logic wr, // Direct write
    input wire logic [W-1:0] wdata, // Write value
    input wire logic inc, // Count one
    output logic [W-1:0] value, // Current count
    output logic wrap // Wraps this cycle
);
    logic [W-1:0] cnt_q;
    assign value = cnt_q;
    assign wrap = inc && !clr && !wr && (cnt_q == {W{1'b1}}); // R15

    always_ff @(posedge core_clk or posedge sys_rst)
        if (sys_rst)
            cnt_q <= '0;
        else if (clr)
            cnt_q <= '0; // R16
        else if (wr)
            cnt_q <= wdata;
        else if (inc)
            cnt_q <= cnt_q + W'(1); // R06 R15
endmodule
`default_nettype wire

// >>> pmc_device.sv
// What this block does
// R01: Warm reset clears global enable; software may clear
// R02: No event counting without global enable
// R03: Counters run only with trace enable set
// R04: 32-bit cycle counter counts every enabled cycle
// R05: Cycle counter zeroed by its reset strobe
// R06: Event counters are 16 bits, count selected events
// R07: Reset-all strobe zeroes every event counter
// R08: Per-counter enable via set and clear writes
// R09: Writable event selector per event counter
// R10: Code zero counts software increment writes only
// R11: Back-to-back increment writes each count
// R12: Odd counter with chain code joins even below
// R13: Odd holds upper half, even lower half
// R14: Software disables counters before reading several
// R15: Wrap to zero carries into chained partner
// R16: Reset strobes keep enables and selectors
// R17: Overflow sets its status bit
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pmc_device #(
    parameter int NUM_EVT = pmc_pkg::NUM_EVT
) (
    input wire logic core_clk, // Processor clock
    input wire logic sys_rst, // Warm reset, async high
    pmc_if.dev link, // Register link
    input wire logic [255:0] core_events, // One pulse per event code
    output logic pmc_active // Global gating state
);
    localparam int EW = pmc_pkg::EVT_W;

    logic mon_en_q;
    logic [31:0] cnt_en_q;
    logic [31:0] ovf_q;
    logic [pmc_pkg::CYC_W-1:0] cyc_q;
    logic [pmc_pkg::SEL_W-1:0] sel_q [NUM_EVT];
    logic [31:0] rdata_q;
    logic [EW-1:0] val [NUM_EVT];
    logic [NUM_EVT-1:0] wrap;
    logic [NUM_EVT-1:0] inc;
    logic [NUM_EVT-1:0] ovf_set;
    logic run;
    logic wr_ctrl, wr_swinc;

    function automatic logic is_wr(input logic [5:0] ofs);
        return link.req && link.wr && (link.addr == ofs);
    endfunction

    assign run = mon_en_q && link.trace_global_enable; // R02 R03
    assign pmc_active = run;
    assign wr_ctrl = is_wr(pmc_pkg::OFS_CTRL);
    assign wr_swinc = is_wr(pmc_pkg::OFS_SW_INC);
    assign link.rdata = rdata_q;

    always_ff @(posedge core_clk or posedge sys_rst)
        if (sys_rst)
            mon_en_q <= 1'b0; // R01
        else if (wr_ctrl)
            mon_en_q <= link.wdata[pmc_pkg::CTRL_EN_BIT]; // R01

    always_ff @(posedge core_clk or posedge sys_rst)
        if (sys_rst)
            cnt_en_q <= '0;
        else if (is_wr(pmc_pkg::OFS_CNT_EN_SET))
            cnt_en_q <= cnt_en_q | link.wdata; // R08
        else if (is_wr(pmc_pkg::OFS_CNT_EN_CLR))
            cnt_en_q <= cnt_en_q & ~link.wdata; // R08

    // Cycle counter, reset value is arbitrary by design; zero is used
    always_ff @(posedge core_clk or posedge sys_rst)
        if (sys_rst)
            cyc_q <= '0;
        else if (wr_ctrl && link.wdata[pmc_pkg::CTRL_CYCRST_BIT])
            cyc_q <= '0; // R05 R16
        else if (is_wr(pmc_pkg::OFS_CYC_VAL))
            cyc_q <= link.wdata;
        else if (run && cnt_en_q[pmc_pkg::CYC_BIT])
            cyc_q <= cyc_q + 32'h0000_0001; // R04

    always_ff @(posedge core_clk or posedge sys_rst)
        if (sys_rst)
            for (int i = 0; i < NUM_EVT; i++)
                sel_q[i] <= '0;
        else
            for (int i = 0; i < NUM_EVT; i++)
                if (is_wr(pmc_pkg::OFS_EVT_SEL0 + 6'(i)))
                    sel_q[i] <= link.wdata[pmc_pkg::SEL_W-1:0]; // R09

    // Increment sources: each software increment write is taken in its own cycle, so none merge
    always_comb
    begin
        for (int i = 0; i < NUM_EVT; i++)
        begin
            if (!(run && cnt_en_q[i]))
                inc[i] = 1'b0; // R02 R08
            else if (sel_q[i] == pmc_pkg::EV_SOFTWARE_INCREMENT_EVENT)
                inc[i] = wr_swinc && link.wdata[i]; // R10 R11
            else if ((i % 2 == 1) && sel_q[i] == pmc_pkg::EV_CHAIN)
                inc[i] = wrap[i-1]; // R12 R13 R15
            else
                inc[i] = core_events[sel_q[i]];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_EVT; g++)
        begin : gen_cnt
            pmc_evt_counter #(.W(EW)) u_cnt (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .clr(wr_ctrl && link.wdata[pmc_pkg::CTRL_EVRST_BIT]), // R07 R16
                .wr(is_wr(pmc_pkg::OFS_EVT_CNT0 + 6'(g))),
                .wdata(link.wdata[EW-1:0]),
                .inc(inc[g]),
                .value(val[g]),
                .wrap(wrap[g])
            );
        end
    endgenerate

    // A chained even half does not flag overflow; only the pair's top does
    always_comb
    begin
        for (int i = 0; i < NUM_EVT; i++)
            ovf_set[i] = wrap[i] && !((i % 2 == 0) && (i + 1 < NUM_EVT)
                && sel_q[(i + 1) % NUM_EVT] == pmc_pkg::EV_CHAIN); // R17
    end

    always_ff @(posedge core_clk or posedge sys_rst)
        if (sys_rst)
            ovf_q <= '0;
        else
            ovf_q <= (ovf_q & ~(is_wr(pmc_pkg::OFS_OVF_CLR) ? link.wdata : 32'h0))
                | {run && cnt_en_q[pmc_pkg::CYC_BIT] && (&cyc_q), {(31 - NUM_EVT){1'b0}}, ovf_set}; // R17

    always_ff @(posedge core_clk or posedge sys_rst)
        if (sys_rst)
            rdata_q <= '0;
        else if (link.req && !link.wr)
        begin
            rdata_q <= '0;
            if (link.addr == pmc_pkg::OFS_CTRL)
                rdata_q <= {31'h0, mon_en_q};
            else if (link.addr == pmc_pkg::OFS_CNT_EN_SET || link.addr == pmc_pkg::OFS_CNT_EN_CLR)
                rdata_q <= cnt_en_q;
            else if (link.addr == pmc_pkg::OFS_OVF_STAT || link.addr == pmc_pkg::OFS_OVF_CLR)
                rdata_q <= ovf_q;
            else if (link.addr == pmc_pkg::OFS_CYC_VAL)
                rdata_q <= cyc_q;
            for (int i = 0; i < NUM_EVT; i++)
            begin
                if (link.addr == pmc_pkg::OFS_EVT_CNT0 + 6'(i))
                    rdata_q <= {16'h0, val[i]}; // R13
                if (link.addr == pmc_pkg::OFS_EVT_SEL0 + 6'(i))
                    rdata_q <= {24'h0, sel_q[i]};
            end
        end
endmodule
`default_nettype wire

// >>> pmc_host.sv
// R14 is software's to keep: the host only carries out the orders written to it.
`timescale 1ns/1ps
`default_nettype none
module pmc_host (
    input wire logic core_clk, // Clock
    input wire logic sys_rst, // Async reset
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hsel, // AHB select
    input wire logic hready, // AHB ready in
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB ready out
    output logic hresp, // AHB response, always OKAY
    output logic irq, // Level interrupt
    pmc_if.host link // Device link
);
    logic ap_q, ap_wr_q;
    logic [7:0] ap_addr_q;
    logic [31:0] wd_q, rd_q, hrdata_q;
    logic [1:0] stat_q, mask_q;
    logic trace_q, busy_q, rd_pend_q;
    logic cmd_wr, stat_rd;

    assign hreadyout = !busy_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign irq = |(stat_q & mask_q);
    assign cmd_wr = ap_q && ap_wr_q && ap_addr_q == pmc_pkg::H_CMD;
    assign stat_rd = ap_q && !ap_wr_q && ap_addr_q == pmc_pkg::H_STAT;
    assign link.trace_global_enable = trace_q; // R03

    always_ff @(posedge core_clk or posedge sys_rst)
        if (sys_rst)
        begin
            ap_q <= 1'b0;
            ap_wr_q <= 1'b0;
            ap_addr_q <= '0;
        end
        else if (hready)
        begin
            ap_q <= hsel && htrans[1];
            ap_wr_q <= hwrite;
            ap_addr_q <= haddr[7:0];
        end

    // Device commands take one cycle to issue and one to read back
    always_ff @(posedge core_clk or posedge sys_rst)
        if (sys_rst)
        begin
            link.req <= 1'b0;
            link.wr <= 1'b0;
            link.addr <= '0;
            link.wdata <= '0;
            busy_q <= 1'b0;
            rd_pend_q <= 1'b0;
        end
        else
        begin
            link.req <= cmd_wr;
            busy_q <= cmd_wr;
            rd_pend_q <= link.req && !link.wr;
            if (cmd_wr)
            begin
                link.wr <= hwdata[pmc_pkg::CMD_WR_BIT];
                link.addr <= hwdata[5:0];
                link.wdata <= wd_q;
            end
        end

    always_ff @(posedge core_clk or posedge sys_rst)
        if (sys_rst)
        begin
            wd_q <= '0;
            mask_q <= '0;
            trace_q <= 1'b0;
        end
        else if (ap_q && ap_wr_q)
        begin
            if (ap_addr_q == pmc_pkg::H_WDATA)
                wd_q <= hwdata;
            if (ap_addr_q == pmc_pkg::H_MASK)
                mask_q <= hwdata[1:0];
            if (ap_addr_q == pmc_pkg::H_TRACE)
                trace_q <= hwdata[0];
        end

    always_ff @(posedge core_clk or posedge sys_rst)
        if (sys_rst)
            rd_q <= '0;
        else if (rd_pend_q)
            rd_q <= link.rdata;

    // Bit0 command done, bit1 read data ready; set wins over the read-clear
    always_ff @(posedge core_clk or posedge sys_rst)
        if (sys_rst)
            stat_q <= '0;
        else
            stat_q <= (stat_rd ? 2'b00 : stat_q) | {rd_pend_q, link.req};

    always_comb
    begin
        hrdata_q = 32'h0;
        if (ap_q && !ap_wr_q)
        begin
            if (ap_addr_q == pmc_pkg::H_WDATA)
                hrdata_q = wd_q;
            else if (ap_addr_q == pmc_pkg::H_RDATA)
                hrdata_q = rd_q;
            else if (ap_addr_q == pmc_pkg::H_STAT)
                hrdata_q = {30'h0, stat_q};
            else if (ap_addr_q == pmc_pkg::H_MASK)
                hrdata_q = {30'h0, mask_q};
            else if (ap_addr_q == pmc_pkg::H_TRACE)
                hrdata_q = {31'h0, trace_q};
        end
    end
endmodule
`default_nettype wire

// >>> pmc_props.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_props (
    input wire logic core_clk, // Clock
    input wire logic sys_rst, // Async reset
    input wire logic req, // Link strobe
    input wire logic wr, // Link write
    input wire logic [5:0] addr, // Link word index
    input wire logic [31:0] wdata, // Link write data
    input wire logic [31:0] rdata, // Link read data
    input wire logic trace_global_enable, // Trace enable
    input wire logic pmc_active // Global gating state
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    localparam logic [31:0] EN_M = 32'h800000ff;
    logic wr_c;
    logic [31:0] en_q;
    logic [31:0] cyc_q;
    logic zero_q;
    logic [7:0] sel_q [8];
    assign wr_c = req && wr;
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst) en_q <= 32'h0;
        else if (wr_c && addr == pmc_pkg::OFS_CNT_EN_SET) en_q <= en_q | wdata;
        else if (wr_c && addr == pmc_pkg::OFS_CNT_EN_CLR) en_q <= en_q & ~wdata;
    end
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst) for (int i = 0; i < 8; i++) sel_q[i] <= 8'h00;
        else if (wr_c && addr[5:3] == 3'b100) sel_q[addr[2:0]] <= wdata[7:0];
    end
    // Model of the cycle count; exact figure catches a missed or extra tick
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst) cyc_q <= 32'h0;
        else if (wr_c && addr == pmc_pkg::OFS_CTRL && wdata[2]) cyc_q <= 32'h0;
        else if (pmc_active && en_q[31]) cyc_q <= cyc_q + 32'h1;
    end
    // Event counters known zero only while no event counter can run
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst) zero_q <= 1'b0;
        else if (wr_c && addr == pmc_pkg::OFS_CTRL && wdata[1] && en_q[7:0] == 8'h00) zero_q <= 1'b1;
        else if (wr_c && (addr[5:4] == 2'b01 || (addr == pmc_pkg::OFS_CNT_EN_SET && wdata[7:0] != 8'h00)))
            zero_q <= 1'b0;
    end
    property p_rst_off;
        $fell(sys_rst) |-> !pmc_active;
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("monitor active after reset");
    property p_ctrl_off;
        wr_c && addr == pmc_pkg::OFS_CTRL && !wdata[0] |=> !pmc_active;
    endproperty
    a_ctrl_off: assert property (p_ctrl_off) else $error("monitor not stopped");
    property p_ctrl_on;
        wr_c && addr == pmc_pkg::OFS_CTRL && wdata[0] && trace_global_enable |=> pmc_active;
    endproperty
    a_ctrl_on: assert property (p_ctrl_on) else $error("monitor not started");
    property p_trace;
        !trace_global_enable |-> !pmc_active;
    endproperty
    a_trace: assert property (p_trace) else $error("active without trace");
    property p_evt_width;
        req && !wr && addr[5:4] == 2'b01 |=> rdata[31:16] == 16'h0000;
    endproperty
    a_evt_width: assert property (p_evt_width) else $error("event count too wide");
    property p_sel;
        req && !wr && addr[5:3] == 3'b100 |=> rdata[7:0] == sel_q[$past(addr[2:0])];
    endproperty
    a_sel: assert property (p_sel) else $error("selector readback");
    property p_en;
        req && !wr && addr == pmc_pkg::OFS_CNT_EN_CLR |=> (rdata & EN_M) == (en_q & EN_M);
    endproperty
    a_en: assert property (p_en) else $error("enable readback");
    property p_cyc;
        req && !wr && addr == pmc_pkg::OFS_CYC_VAL |=> rdata == $past(cyc_q);
    endproperty
    a_cyc: assert property (p_cyc) else $error("cycle count");
    property p_zero;
        req && !wr && addr[5:4] == 2'b01 && zero_q |=> rdata == 32'h0;
    endproperty
    a_zero: assert property (p_zero) else $error("counter not zeroed");
endmodule
`default_nettype wire

// >>> perf_monitor_counters_test.sv
`timescale 1ns/1ps
`default_nettype none
module perf_monitor_counters_test;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic hsel = 1'b0;
    logic [255:0] core_events = 256'h0;
    logic [31:0] hrdata, r, q1, q2;
    logic hreadyout, hresp, irq, pmc_active;
    int fail_count = 0;
    int checks = 0;
    pmc_if u_pmc_if();
    pmc_host u_pmc_host (.core_clk(core_clk), .sys_rst(sys_rst), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .link(u_pmc_if));
    pmc_device u_pmc_device (.core_clk(core_clk), .sys_rst(sys_rst), .link(u_pmc_if),
        .core_events(core_events), .pmc_active(pmc_active));
    pmc_props u_pmc_props (.core_clk(core_clk), .sys_rst(sys_rst), .req(u_pmc_if.req), .wr(u_pmc_if.wr),
        .addr(u_pmc_if.addr), .wdata(u_pmc_if.wdata), .rdata(u_pmc_if.rdata),
        .trace_global_enable(u_pmc_if.trace_global_enable), .pmc_active(pmc_active));
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end
    task automatic stop_test();
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Address phase held until hready, data phase held until hready again
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic dwr(input logic [5:0] o, input logic [31:0] d);
        logic [31:0] s;
        ahb(1'b1, pmc_pkg::H_WDATA, d, s);
        ahb(1'b1, pmc_pkg::H_CMD, {26'h1 << 2, o}, s);
    endtask
    task automatic drd(input logic [5:0] o, output logic [31:0] q);
        q = 32'h0;
        ahb(1'b1, pmc_pkg::H_CMD, {26'h0, o}, q);
        for (int i = 0; i < 10 && q[1] !== 1'b1; i++) ahb(1'b0, pmc_pkg::H_STAT, 32'h0, q);
        ahb(1'b0, pmc_pkg::H_RDATA, 32'h0, q);
    endtask
    task automatic rc(input logic [5:0] o, input logic [31:0] e);
        logic [31:0] q;
        drd(o, q);
        chk(q, e);
    endtask
    task automatic pulse(input int c, input int n);
        repeat (n)
        begin
            @(posedge core_clk) core_events[c] <= 1'b1;
            @(posedge core_clk) core_events[c] <= 1'b0;
        end
    endtask
    initial
    begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        stop_test();
    end
    initial
    begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        chk({31'h0, pmc_active}, 32'h0);
        rc(pmc_pkg::OFS_CTRL, 32'h0);
        ahb(1'b1, pmc_pkg::H_MASK, 32'h1, r);
        dwr(pmc_pkg::OFS_EVT_SEL0, 32'h08);
        // Done bit lands on the edge after the link strobe, so look one edge later
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        ahb(1'b0, pmc_pkg::H_STAT, 32'h0, r);
        chk({31'h0, r[0]}, 32'h1);
        @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        ahb(1'b1, pmc_pkg::H_MASK, 32'h0, r);
        dwr(pmc_pkg::OFS_EVT_SEL0 + 6'h1, 32'h0);
        chk({31'h0, irq}, 32'h0);
        ahb(1'b0, pmc_pkg::H_STAT, 32'h0, r);
        dwr(pmc_pkg::OFS_EVT_SEL0 + 6'h6, 32'h11);
        dwr(pmc_pkg::OFS_EVT_SEL0 + 6'h7, {24'h0, pmc_pkg::EV_CHAIN});
        ahb(1'b1, pmc_pkg::H_TRACE, 32'h1, r);
        dwr(pmc_pkg::OFS_CTRL, 32'h7);
        repeat (2) @(posedge core_clk);
        chk({31'h0, pmc_active}, 32'h1);
        dwr(pmc_pkg::OFS_CNT_EN_SET, 32'h3);
        pulse(8, 5);
        pulse(0, 2);
        dwr(pmc_pkg::OFS_SW_INC, 32'h2);
        dwr(pmc_pkg::OFS_SW_INC, 32'h2);
        dwr(pmc_pkg::OFS_CNT_EN_CLR, 32'h3);
        rc(pmc_pkg::OFS_EVT_CNT0, 32'h5);
        rc(pmc_pkg::OFS_EVT_CNT0 + 6'h1, 32'h2);
        rc(pmc_pkg::OFS_CNT_EN_CLR, 32'h0);
        dwr(pmc_pkg::OFS_CNT_EN_SET, 32'h3);
        dwr(pmc_pkg::OFS_CTRL, 32'h0);
        pulse(8, 3);
        dwr(pmc_pkg::OFS_SW_INC, 32'h2);
        ahb(1'b1, pmc_pkg::H_TRACE, 32'h0, r);
        dwr(pmc_pkg::OFS_CTRL, 32'h1);
        pulse(8, 3);
        rc(pmc_pkg::OFS_EVT_CNT0, 32'h5);
        rc(pmc_pkg::OFS_EVT_CNT0 + 6'h1, 32'h2);
        // Wrap and chain carry checked in one run
        ahb(1'b1, pmc_pkg::H_TRACE, 32'h1, r);
        dwr(pmc_pkg::OFS_EVT_CNT0 + 6'h6, 32'hfffe);
        dwr(pmc_pkg::OFS_EVT_CNT0, 32'hffff);
        dwr(pmc_pkg::OFS_CNT_EN_SET, 32'hc1);
        pulse(8, 1);
        pulse(8'h11, 3);
        dwr(pmc_pkg::OFS_CNT_EN_CLR, 32'hc3);
        rc(pmc_pkg::OFS_EVT_CNT0 + 6'h6, 32'h1);
        rc(pmc_pkg::OFS_EVT_CNT0 + 6'h7, 32'h1);
        rc(pmc_pkg::OFS_EVT_CNT0, 32'h0);
        rc(pmc_pkg::OFS_OVF_STAT, 32'h1);
        dwr(pmc_pkg::OFS_CTRL, 32'h5);
        dwr(pmc_pkg::OFS_CNT_EN_SET, 32'h80000000);
        repeat (20) @(posedge core_clk);
        dwr(pmc_pkg::OFS_CNT_EN_CLR, 32'h80000000);
        drd(pmc_pkg::OFS_CYC_VAL, q1);
        drd(pmc_pkg::OFS_CYC_VAL, q2);
        chk(q2, q1);
        chk({31'h0, q1 > 32'd20}, 32'h1);
        dwr(pmc_pkg::OFS_CTRL, 32'h5);
        rc(pmc_pkg::OFS_CYC_VAL, 32'h0);
        dwr(pmc_pkg::OFS_CTRL, 32'h3);
        rc(pmc_pkg::OFS_EVT_CNT0 + 6'h6, 32'h0);
        rc(pmc_pkg::OFS_EVT_SEL0, 32'h08);
        rc(pmc_pkg::OFS_EVT_SEL0 + 6'h7, {24'h0, pmc_pkg::EV_CHAIN});
        ahb(1'b1, 8'h20, 32'h5a5a5a5a, r);
        ahb(1'b0, 8'h20, 32'h0, r);
        chk(r, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
